/* hw/pxh_consts.svh */
`ifndef PXH_CONSTS_SVH
`define PXH_CONSTS_SVH

// ==========================================================================
// timing counts, in cycles of the single input clock
`define PXH_RESET_MIN_CYCLES   4'hA
`define PXH_MEM_WAIT_CYCLES    4'h3
`define PXH_CNT_W              4

// ==========================================================================
// field positions
`define PXH_REG_ADDR_LSB       2
`define PXH_REG_ADDR_MSB       8
`define PXH_WORD_SEL_BIT       0
`define PXH_HALF_W             16

// ==========================================================================
// reset values
`define PXH_ADDR_RST           30'h0000_0000
`define PXH_BE_RST             4'hF
`define PXH_DATA_RST           32'h0000_0000

`endif

/* hw/pxh_dev.sv */
`include "pxh_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pxh_dev #(
  parameter logic [`PXH_CNT_W-1:0] MEM_WAIT = `PXH_MEM_WAIT_CYCLES
) (
  // clock, reset, enable
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_srst,
  input  wire logic                     i_clk_en,
  // link to the host
  pxh_if.dev_mp                         bus,
  // device's own use of the shared buses
  input  wire logic                     i_own_drive,
  input  wire logic [31:2]              i_own_addr,
  input  wire logic [3:0]               i_own_be,
  input  wire logic [31:0]              i_own_data,
  // register file side
  output logic                          o_reg_wr,
  output logic                          o_reg_rd,
  output logic [6:0]                    o_reg_addr,
  output logic                          o_reg_word_sel,
  output logic [`PXH_HALF_W-1:0]        o_reg_wdata,
  input  wire logic [`PXH_HALF_W-1:0]   i_reg_rdata,
  // memory and external cycle side
  output logic                          o_mem_cycle,
  output logic                          o_ext_cycle,
  output logic                          o_cyc_we,
  input  wire logic                     i_ext_ack,
  // status
  output logic                          o_init_done,
  output pxh_pkg::pxh_dev_state_e       o_state
);
  import pxh_pkg::*;

  // ==========================================================================
  // documented reset: counted, since a short pulse must not initialise
  logic [`PXH_CNT_W-1:0] rst_cnt_reg;
  logic                  init_done_reg;
  logic                  dev_rst;

  assign dev_rst = i_srst || !bus.device_reset_n;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      rst_cnt_reg   <= '0;
      init_done_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (!bus.device_reset_n) begin
        init_done_reg <= 1'b0;
        if (rst_cnt_reg != {`PXH_CNT_W{1'b1}}) begin
          rst_cnt_reg <= rst_cnt_reg + 1'b1;
        end
      end else begin
        if (rst_cnt_reg >= `PXH_RESET_MIN_CYCLES) begin
          init_done_reg <= 1'b1;
        end
        rst_cnt_reg <= '0;
      end
    end
  end

  // ==========================================================================
  // cycle decode; memory select wins if the host breaks the pairing
  pxh_cyc_e cyc_decode;
  pxh_cyc_e cyc_reg;

  always_comb begin
    if (!bus.shared_memory_select_n) begin
      cyc_decode = PXH_CYC_MEM;
    end else if (!bus.register_select_n) begin
      cyc_decode = PXH_CYC_REG;
    end else begin
      cyc_decode = PXH_CYC_EXT;
    end
  end

  // ==========================================================================
  // access sequencer
  pxh_dev_state_e        state_reg;
  logic                  we_reg;
  logic [`PXH_CNT_W-1:0] wait_reg;
  logic                  release_n_reg;
  logic                  done_n_reg;

  always_ff @(posedge i_sys_clk) begin
    if (dev_rst) begin
      state_reg     <= DS_IDLE;
      cyc_reg       <= PXH_CYC_EXT;
      we_reg        <= 1'b0;
      wait_reg      <= '0;
      release_n_reg <= 1'b1;
      done_n_reg    <= 1'b1;
    end else if (i_clk_en) begin
      case (state_reg)
        DS_IDLE: begin
          if (init_done_reg && !bus.host_access_request_n) begin
            cyc_reg   <= cyc_decode;
            state_reg <= DS_FLOAT;
          end
        end
        DS_FLOAT: begin
          release_n_reg <= 1'b0;
          state_reg     <= DS_WAIT_STB;
        end
        DS_WAIT_STB: begin
          if (!bus.host_address_strobe_n) begin
            we_reg    <= !bus.write_enable_n;
            wait_reg  <= MEM_WAIT;
            state_reg <= DS_ACCESS;
          end
        end
        DS_ACCESS: begin
          case (cyc_reg)
            PXH_CYC_MEM: begin
              if (wait_reg <= `PXH_CNT_W'(1)) begin
                done_n_reg <= 1'b0;
                state_reg  <= DS_DONE;
              end else begin
                wait_reg <= wait_reg - 1'b1;
              end
            end
            PXH_CYC_EXT: begin
              if (i_ext_ack) begin
                done_n_reg <= 1'b0;
                state_reg  <= DS_DONE;
              end
            end
            default: begin
              done_n_reg <= 1'b0;
              state_reg  <= DS_DONE;
            end
          endcase
        end
        DS_DONE: begin
          done_n_reg <= 1'b1;
          state_reg  <= DS_END;
        end
        DS_END: begin
          if (bus.host_access_request_n) begin
            release_n_reg <= 1'b1;
            state_reg     <= DS_IDLE;
          end
        end
        default: begin
          state_reg <= DS_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // register access side: pulses, address and write word
  logic       strobe_now;
  logic       word_hi;
  logic       reg_wr_reg;
  logic       reg_rd_reg;
  logic [6:0] reg_addr_reg;
  logic       word_sel_reg;
  logic [`PXH_HALF_W-1:0] wdata_reg;
  logic       mem_cyc_reg;
  logic       ext_cyc_reg;

  assign strobe_now = (state_reg == DS_WAIT_STB) && !bus.host_address_strobe_n;
  assign word_hi    = !bus.be[`PXH_WORD_SEL_BIT];

  always_ff @(posedge i_sys_clk) begin
    if (dev_rst) begin
      reg_wr_reg   <= 1'b0;
      reg_rd_reg   <= 1'b0;
      reg_addr_reg <= '0;
      word_sel_reg <= 1'b0;
      wdata_reg    <= '0;
      mem_cyc_reg  <= 1'b0;
      ext_cyc_reg  <= 1'b0;
    end else if (i_clk_en) begin
      reg_wr_reg  <= strobe_now && (cyc_reg == PXH_CYC_REG) && !bus.write_enable_n;
      reg_rd_reg  <= strobe_now && (cyc_reg == PXH_CYC_REG) && bus.write_enable_n;
      mem_cyc_reg <= strobe_now && (cyc_reg == PXH_CYC_MEM);
      ext_cyc_reg <= strobe_now && (cyc_reg == PXH_CYC_EXT);
      if (strobe_now && (cyc_reg == PXH_CYC_REG)) begin
        reg_addr_reg <= bus.addr[`PXH_REG_ADDR_MSB:`PXH_REG_ADDR_LSB];
        word_sel_reg <= word_hi;
        wdata_reg    <= word_hi ? bus.data[31:16] : bus.data[15:0];
      end
    end
  end

  // ==========================================================================
  // bus drive: own use only while idle; address floated for the whole host access, data driven back on register reads
  logic [31:2] addr_o_reg;
  logic        addr_oe_n_reg;
  logic [3:0]  be_o_reg;
  logic [31:0] data_o_reg;
  logic        data_oe_n_reg;
  logic        own_slot;

  assign own_slot = (state_reg == DS_IDLE) && init_done_reg && i_own_drive &&
                    bus.host_access_request_n;

  always_ff @(posedge i_sys_clk) begin
    if (dev_rst) begin
      addr_o_reg    <= `PXH_ADDR_RST;
      addr_oe_n_reg <= 1'b1;
      be_o_reg      <= `PXH_BE_RST;
      data_o_reg    <= `PXH_DATA_RST;
      data_oe_n_reg <= 1'b1;
    end else if (i_clk_en) begin
      addr_oe_n_reg <= !own_slot;
      if (own_slot) begin
        addr_o_reg    <= i_own_addr;
        be_o_reg      <= i_own_be;
        data_o_reg    <= i_own_data;
        data_oe_n_reg <= 1'b0;
      end else if (state_reg == DS_ACCESS && cyc_reg == PXH_CYC_REG && !we_reg) begin
        // read word placed on the half picked at the strobe
        data_o_reg    <= word_sel_reg ? {i_reg_rdata, 16'h0000}
                                      : {16'h0000, i_reg_rdata};
        data_oe_n_reg <= 1'b0;
      end else if (state_reg == DS_IDLE || state_reg == DS_FLOAT ||
                   state_reg == DS_WAIT_STB) begin
        data_oe_n_reg <= 1'b1;
      end else if (state_reg == DS_END && bus.host_access_request_n) begin
        data_oe_n_reg <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // outputs
  assign bus.bus_release_indication_n = release_n_reg;
  assign bus.host_access_done_n       = done_n_reg;
  assign bus.addr_dev_o               = addr_o_reg;
  assign bus.addr_dev_oe_n            = addr_oe_n_reg;
  assign bus.be_dev_o                 = be_o_reg;
  assign bus.be_dev_oe_n              = addr_oe_n_reg;
  assign bus.data_dev_o               = data_o_reg;
  assign bus.data_dev_oe_n            = data_oe_n_reg;
  assign o_reg_wr                     = reg_wr_reg;
  assign o_reg_rd                     = reg_rd_reg;
  assign o_reg_addr                   = reg_addr_reg;
  assign o_reg_word_sel               = word_sel_reg;
  assign o_reg_wdata                  = wdata_reg;
  assign o_mem_cycle                  = mem_cyc_reg;
  assign o_ext_cycle                  = ext_cyc_reg;
  assign o_cyc_we                     = we_reg;
  assign o_init_done                  = init_done_reg;
  assign o_state                      = state_reg;

endmodule

`default_nettype wire

/* hw/pxh_host.sv */
`include "pxh_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pxh_host #(
  parameter logic [`PXH_CNT_W-1:0] RESET_HOLD = `PXH_RESET_MIN_CYCLES
) (
  // clock, reset, enable
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_srst,
  input  wire logic                 i_clk_en,
  // link to the device
  pxh_if.host_mp                    bus,
  // command side
  input  wire logic                 i_cmd_valid,
  output logic                      o_cmd_ready,
  input  wire pxh_pkg::pxh_cyc_e    i_cmd_kind,
  input  wire logic                 i_cmd_we,
  input  wire logic [31:2]          i_cmd_addr,
  input  wire logic [3:0]           i_cmd_be,
  input  wire logic [31:0]          i_cmd_wdata,
  // response side
  output logic                      o_rsp_valid,
  output logic [31:0]               o_rsp_rdata
);
  import pxh_pkg::*;

  // ==========================================================================
  // device reset: held at least the minimum after every system reset
  logic [`PXH_CNT_W-1:0] hold_reg;
  logic                  dev_rst_n_reg;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      hold_reg      <= '0;
      dev_rst_n_reg <= 1'b0;
    end else if (i_clk_en && !dev_rst_n_reg) begin
      if (hold_reg >= RESET_HOLD - 1'b1) begin
        dev_rst_n_reg <= 1'b1;
      end else begin
        hold_reg <= hold_reg + 1'b1;
      end
    end
  end

  // ==========================================================================
  // access sequencer
  pxh_host_state_e state_reg;
  logic            req_n_reg;
  logic            regsel_n_reg;
  logic            memsel_n_reg;
  logic            we_n_reg;
  logic            stb_n_reg;
  logic            drive_n_reg;
  logic            wdrive_n_reg;
  logic [31:2]     addr_reg;
  logic [3:0]      be_reg;
  logic [31:0]     wdata_reg;
  logic            rsp_valid_reg;
  logic [31:0]     rdata_reg;

  assign o_cmd_ready = (state_reg == HS_IDLE) && dev_rst_n_reg;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst || !dev_rst_n_reg) begin
      state_reg     <= HS_IDLE;
      req_n_reg     <= 1'b1;
      regsel_n_reg  <= 1'b1;
      memsel_n_reg  <= 1'b1;
      we_n_reg      <= 1'b1;
      stb_n_reg     <= 1'b1;
      drive_n_reg   <= 1'b1;
      wdrive_n_reg  <= 1'b1;
      addr_reg      <= `PXH_ADDR_RST;
      be_reg        <= `PXH_BE_RST;
      wdata_reg     <= `PXH_DATA_RST;
      rsp_valid_reg <= 1'b0;
      rdata_reg     <= `PXH_DATA_RST;
    end else if (i_clk_en) begin
      rsp_valid_reg <= 1'b0;
      case (state_reg)
        HS_IDLE: begin
          if (i_cmd_valid) begin
            req_n_reg    <= 1'b0;
            regsel_n_reg <= !(i_cmd_kind == PXH_CYC_REG);
            memsel_n_reg <= !(i_cmd_kind == PXH_CYC_MEM);
            we_n_reg     <= !i_cmd_we;
            addr_reg     <= i_cmd_addr;
            be_reg       <= i_cmd_be;
            wdata_reg    <= i_cmd_wdata;
            state_reg    <= HS_REQ;
          end
        end
        HS_REQ: begin
          if (!bus.bus_release_indication_n) begin
            drive_n_reg  <= 1'b0;
            wdrive_n_reg <= we_n_reg;
            stb_n_reg    <= 1'b0;
            state_reg    <= HS_WAIT;
          end
        end
        HS_WAIT: begin
          if (!bus.host_access_done_n) begin
            rdata_reg     <= bus.data;
            rsp_valid_reg <= 1'b1;
            req_n_reg     <= 1'b1;
            stb_n_reg     <= 1'b1;
            drive_n_reg   <= 1'b1;
            wdrive_n_reg  <= 1'b1;
            regsel_n_reg  <= 1'b1;
            memsel_n_reg  <= 1'b1;
            state_reg     <= HS_DROP;
          end
        end
        HS_DROP: begin
          // wait for the device to take the buses back before a new request
          if (bus.bus_release_indication_n) begin
            state_reg <= HS_IDLE;
          end
        end
        default: begin
          state_reg <= HS_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // outputs
  assign bus.device_reset_n         = dev_rst_n_reg;
  assign bus.host_access_request_n  = req_n_reg;
  assign bus.register_select_n      = regsel_n_reg;
  assign bus.shared_memory_select_n = memsel_n_reg;
  assign bus.write_enable_n         = we_n_reg;
  assign bus.host_address_strobe_n  = stb_n_reg;
  assign bus.addr_host_o            = addr_reg;
  assign bus.addr_host_oe_n         = drive_n_reg;
  assign bus.be_host_o              = be_reg;
  assign bus.be_host_oe_n           = drive_n_reg;
  assign bus.data_host_o            = wdata_reg;
  assign bus.data_host_oe_n         = wdrive_n_reg;
  assign o_rsp_valid                = rsp_valid_reg;
  assign o_rsp_rdata                = rdata_reg;

endmodule

`default_nettype wire

/* hw/pxh_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface pxh_if;
  // ==========================================================================
  // control strobes, all active low
  logic        device_reset_n;
  logic        host_access_request_n;
  logic        register_select_n;
  logic        shared_memory_select_n;
  logic        write_enable_n;
  logic        host_address_strobe_n;
  logic        bus_release_indication_n;
  logic        host_access_done_n;

  // ==========================================================================
  // shared buses: each end drives with its own enable, low = driving
  logic [31:2] addr_dev_o;
  logic        addr_dev_oe_n;
  logic [31:2] addr_host_o;
  logic        addr_host_oe_n;
  logic [3:0]  be_dev_o;
  logic        be_dev_oe_n;
  logic [3:0]  be_host_o;
  logic        be_host_oe_n;
  logic [31:0] data_dev_o;
  logic        data_dev_oe_n;
  logic [31:0] data_host_o;
  logic        data_host_oe_n;
  logic [31:2] addr;
  logic [3:0]  be;
  logic [31:0] data;

  // an undriven bus reads as zero, byte enables as all ones; a clash favours the device
  assign addr = !addr_dev_oe_n ? addr_dev_o : (!addr_host_oe_n ? addr_host_o : 30'h0);
  assign be   = !be_dev_oe_n ? be_dev_o : (!be_host_oe_n ? be_host_o : 4'hF);
  assign data = !data_dev_oe_n ? data_dev_o : (!data_host_oe_n ? data_host_o : 32'h0);

  modport dev_mp (
    input  device_reset_n, host_access_request_n, register_select_n,
    input  shared_memory_select_n, write_enable_n, host_address_strobe_n,
    output bus_release_indication_n, host_access_done_n,
    output addr_dev_o, addr_dev_oe_n, be_dev_o, be_dev_oe_n, data_dev_o, data_dev_oe_n,
    input  addr, be, data
  );

  modport host_mp (
    output device_reset_n, host_access_request_n, register_select_n,
    output shared_memory_select_n, write_enable_n, host_address_strobe_n,
    input  bus_release_indication_n, host_access_done_n,
    output addr_host_o, addr_host_oe_n, be_host_o, be_host_oe_n, data_host_o, data_host_oe_n,
    input  addr, be, data
  );
endinterface

`default_nettype wire

/* hw/pxh_pkg.sv */
package pxh_pkg;

  // ==========================================================================
  // cycle kinds
  typedef enum logic [1:0] {
    PXH_CYC_REG = 2'h0,
    PXH_CYC_MEM = 2'h1,
    PXH_CYC_EXT = 2'h2
  } pxh_cyc_e;

  // ==========================================================================
  // device end states
  typedef enum logic [5:0] {
    DS_IDLE     = 6'b000001,
    DS_FLOAT    = 6'b000010,
    DS_WAIT_STB = 6'b000100,
    DS_ACCESS   = 6'b001000,
    DS_DONE     = 6'b010000,
    DS_END      = 6'b100000
  } pxh_dev_state_e;

  // ==========================================================================
  // host end states
  typedef enum logic [3:0] {
    HS_IDLE = 4'b0001,
    HS_REQ  = 4'b0010,
    HS_WAIT = 4'b0100,
    HS_DROP = 4'b1000
  } pxh_host_state_e;

endpackage

/* testbench/pxh_properties.sv */
`timescale 1ns/1ps
`default_nettype none

module pxh_properties (
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_srst,
  // link strobes
  input  wire logic device_reset_n,
  input  wire logic host_access_request_n,
  input  wire logic register_select_n,
  input  wire logic shared_memory_select_n,
  input  wire logic host_address_strobe_n,
  input  wire logic bus_release_indication_n,
  input  wire logic host_access_done_n,
  // bus enables
  input  wire logic addr_dev_oe_n,
  input  wire logic be_dev_oe_n,
  input  wire logic data_dev_oe_n,
  input  wire logic addr_host_oe_n
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);

  // ========
  // low time of the device reset, saturating so a long hold never wraps;
  // cleared by system reset too, else it stays unknown from power-up
  logic [3:0] low_cnt_reg;
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || device_reset_n) low_cnt_reg <= 4'h0;
    else if (low_cnt_reg != 4'hF) low_cnt_reg <= low_cnt_reg + 4'h1;
  end

  // ========
  // properties
  property p_reset_hold; $rose(device_reset_n) |-> low_cnt_reg >= 4'hA; endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset held too short");
  property p_release_lat; $fell(host_access_request_n) |-> ##2 $fell(bus_release_indication_n);
  endproperty
  a_release_lat: assert property (p_release_lat) else $error("release late");
  property p_float; !bus_release_indication_n |-> addr_dev_oe_n && be_dev_oe_n; endproperty
  a_float: assert property (p_float) else $error("device drives while released");
  property p_data_float; $fell(bus_release_indication_n) |-> data_dev_oe_n; endproperty
  a_data_float: assert property (p_data_float) else $error("data not floated");
  property p_release_req; $fell(bus_release_indication_n) |-> !host_access_request_n; endproperty
  a_release_req: assert property (p_release_req) else $error("release without request");
  property p_host_drive; !addr_host_oe_n |-> !bus_release_indication_n; endproperty
  a_host_drive: assert property (p_host_drive) else $error("host drives early");
  property p_strobe; $fell(host_address_strobe_n) |-> !bus_release_indication_n && !addr_host_oe_n;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe without address");
  property p_reg_done;
    $fell(host_address_strobe_n) && !register_select_n |-> ##2 $fell(host_access_done_n);
  endproperty
  a_reg_done: assert property (p_reg_done) else $error("register done late");
  // memory wait fixed at the device default of three
  property p_mem_done; $fell(host_address_strobe_n) && register_select_n &&
    !shared_memory_select_n |-> ##4 $fell(host_access_done_n); endproperty
  a_mem_done: assert property (p_mem_done) else $error("memory done late");
  property p_done_pulse; !host_access_done_n |=> host_access_done_n; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  property p_release_end; $rose(host_access_request_n) |-> ##1 $rose(bus_release_indication_n);
  endproperty
  a_release_end: assert property (p_release_end) else $error("release held");
  property p_one_sel; !host_access_request_n |-> register_select_n || shared_memory_select_n;
  endproperty
  a_one_sel: assert property (p_one_sel) else $error("both selects active");
endmodule

`default_nettype wire

/* testbench/test_pixel_proc_host_access_port.sv */
`timescale 1ns/1ps
`default_nettype none

module test_pixel_proc_host_access_port;
  import pxh_pkg::*;
  // ========
  // stimulus and observed signals
  logic        i_sys_clk;
  logic        i_srst;
  logic        cmd_valid;
  pxh_cyc_e    cmd_kind;
  logic        cmd_we;
  logic [31:2] cmd_addr;
  logic [3:0]  cmd_be;
  logic [31:0] cmd_wdata;
  logic [15:0] reg_rdata;
  logic        ext_ack = 1'b0;
  logic        own_drive;
  logic [31:2] own_addr;
  logic        cmd_ready, rsp_valid, reg_wr, reg_rd, word_sel, mem_cyc, ext_cyc, cyc_we, init_done;
  logic [6:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [31:0] rsp_rdata;
  pxh_dev_state_e dev_state;
  int          n_wr = 0, n_rd = 0, n_mem = 0, n_ext = 0, ext_wait = 0;
  int          mismatches = 0, checks_done = 0;

  initial begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end

  pxh_if bus_if ();
  pxh_dev pxh_dev_i (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_clk_en(1'b1), .bus(bus_if),
    .i_own_drive(own_drive), .i_own_addr(own_addr), .i_own_be(4'h0), .i_own_data(32'h0000_5A5A),
    .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_reg_addr(reg_addr), .o_reg_word_sel(word_sel),
    .o_reg_wdata(reg_wdata), .i_reg_rdata(reg_rdata), .o_mem_cycle(mem_cyc),
    .o_ext_cycle(ext_cyc), .o_cyc_we(cyc_we), .i_ext_ack(ext_ack), .o_init_done(init_done),
    .o_state(dev_state));
  pxh_host pxh_host_i (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_clk_en(1'b1), .bus(bus_if),
    .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready), .i_cmd_kind(cmd_kind), .i_cmd_we(cmd_we),
    .i_cmd_addr(cmd_addr), .i_cmd_be(cmd_be), .i_cmd_wdata(cmd_wdata),
    .o_rsp_valid(rsp_valid), .o_rsp_rdata(rsp_rdata));
  pxh_properties pxh_properties_i (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
    .device_reset_n(bus_if.device_reset_n), .host_access_request_n(bus_if.host_access_request_n),
    .register_select_n(bus_if.register_select_n),
    .shared_memory_select_n(bus_if.shared_memory_select_n),
    .host_address_strobe_n(bus_if.host_address_strobe_n),
    .bus_release_indication_n(bus_if.bus_release_indication_n),
    .host_access_done_n(bus_if.host_access_done_n), .addr_dev_oe_n(bus_if.addr_dev_oe_n),
    .be_dev_oe_n(bus_if.be_dev_oe_n), .data_dev_oe_n(bus_if.data_dev_oe_n),
    .addr_host_oe_n(bus_if.addr_host_oe_n));

  // ========
  // pulse counters and an external device that acks four cycles after each ext_cyc pulse
  always @(posedge i_sys_clk) begin
    n_wr <= n_wr + int'(reg_wr);
    n_rd <= n_rd + int'(reg_rd);
    n_mem <= n_mem + int'(mem_cyc);
    n_ext <= n_ext + int'(ext_cyc);
    ext_wait <= ext_cyc ? 1 : ((ext_wait != 0 && ext_wait < 4) ? ext_wait + 1 : 0);
    ext_ack <= (ext_wait == 3);
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // settled sampling, one ns after each edge; exhaustion ends the run
  task automatic wait_hi(input bit rsp);
    int i;
    for (i = 0; i < 200 && (rsp ? rsp_valid : cmd_ready) !== 1'b1; i++) begin
      @(posedge i_sys_clk);
      #1;
    end
    if (i == 200) begin
      mismatches++;
      conclude();
    end
  endtask

  task automatic do_reset();
    @(posedge i_sys_clk);
    i_srst <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    #1;
    wait_hi(1'b0);
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk("init done", 32'h1, 32'(init_done));
    chk("idle state", 32'(DS_IDLE), 32'(dev_state));
    chk("idle own addr", 32'(own_addr), 32'(bus_if.addr));
  endtask

  task automatic run(input pxh_cyc_e kind, input logic we, input logic [31:2] addr,
                     input logic [3:0] be, input logic [31:0] wd, input logic [15:0] rd);
    int w0, r0, m0, e0;
    w0 = n_wr;
    r0 = n_rd;
    m0 = n_mem;
    e0 = n_ext;
    wait_hi(1'b0);
    @(posedge i_sys_clk);
    reg_rdata <= rd;
    cmd_valid <= 1'b1;
    cmd_kind <= kind;
    cmd_we <= we;
    cmd_addr <= addr;
    cmd_be <= be;
    cmd_wdata <= wd;
    @(posedge i_sys_clk);
    cmd_valid <= 1'b0;
    #1;
    wait_hi(1'b1);
    chk("reg writes", 32'(w0 + int'(kind == PXH_CYC_REG && we)), 32'(n_wr));
    chk("reg reads", 32'(r0 + int'(kind == PXH_CYC_REG && !we)), 32'(n_rd));
    chk("mem cycles", 32'(m0 + int'(kind == PXH_CYC_MEM)), 32'(n_mem));
    chk("ext cycles", 32'(e0 + int'(kind == PXH_CYC_EXT)), 32'(n_ext));
    chk("cycle we", 32'(we), 32'(cyc_we));
    if (kind == PXH_CYC_REG) begin
      chk("reg addr", 32'(addr[8:2]), 32'(reg_addr));
      chk("word sel", 32'(!be[0]), 32'(word_sel));
      if (we) chk("reg wdata", 32'(be[0] ? wd[15:0] : wd[31:16]), 32'(reg_wdata));
      else chk("read half", 32'(rd), 32'(be[0] ? rsp_rdata[15:0] : rsp_rdata[31:16]));
    end
  endtask

  // ========
  // main sequence
  initial begin
    i_srst = 1'b1;
    cmd_valid = 1'b0;
    cmd_kind = PXH_CYC_REG;
    cmd_we = 1'b0;
    cmd_addr = 30'h0;
    cmd_be = 4'hF;
    cmd_wdata = 32'h0;
    reg_rdata = 16'h0;
    own_drive = 1'b1;
    own_addr = 30'h2AAA_5555;
    do_reset();
    run(PXH_CYC_REG, 1'b1, 30'h0000_007F, 4'hE, 32'hBEEF_1234, 16'h0000);
    run(PXH_CYC_REG, 1'b1, 30'h3FFF_FF80, 4'hF, 32'h0F0F_A55A, 16'h0000);
    run(PXH_CYC_REG, 1'b0, 30'h0000_0015, 4'hE, 32'h0, 16'hC3A5);
    run(PXH_CYC_REG, 1'b0, 30'h0000_006A, 4'hF, 32'h0, 16'h5A3C);
    run(PXH_CYC_MEM, 1'b1, 30'h0000_1234, 4'h3, 32'h1111_2222, 16'h0);
    run(PXH_CYC_MEM, 1'b0, 30'h0012_3400, 4'hF, 32'h0, 16'h0);
    run(PXH_CYC_EXT, 1'b1, 30'h0000_0040, 4'hF, 32'h3333_4444, 16'h0);
    run(PXH_CYC_EXT, 1'b0, 30'h0000_0041, 4'hF, 32'h0, 16'h0);
    // a second reset mid-run must re-initialise before new traffic
    do_reset();
    run(PXH_CYC_REG, 1'b0, 30'h0000_0001, 4'hE, 32'h0, 16'h8001);
    conclude();
  end
endmodule

`default_nettype wire
